// *** src/rx_recovery.sv ***
// asynchronous serial receiver: start detect, majority vote, two-entry buffer
// Notes on behaviour
// - clearing enable aborts a frame in flight
// - disabled receiver releases the input pin
// - disabling empties buffer; done flag clears
// - sample at 16x, or 8x in double speed
// - idle falling edge starts detection, sample one
// - start checked at 8-10, or 4-6
// - two high start samples mean noise
// - bit timing realigned at every start
// - 16 or 8 sample states per bit
// - three-sample majority decides each bit
// - votes centred on sample 9 or 5
// - recover through first stop, ignore others
// - zero first stop sets framing error
// - next start detectable after last vote
// - data plus parity length five to ten
// - first stop moves character into buffer
`timescale 1ns/1ps
`default_nettype none
module rx_recovery
  import rx_recovery_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // oversampling tick from the baud generator
  input  wire logic        sample_tick_i,
  // serial line
  input  wire logic        serial_input_pin_i,
  output logic             pin_takeover_o,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  output logic [15:0]      rdata_o,
  // interrupt
  output logic             irq_o
);

  // register state
  logic [7:0]       ctrl_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [15:0]      rdata_q;

  logic       rx_en;
  logic       dbl;
  logic [3:0] frame_bits;
  assign rx_en      = ctrl_q[CTRL_RX_EN_BIT];
  assign dbl        = ctrl_q[CTRL_DBL_BIT];
  assign frame_bits = (ctrl_q[CTRL_BITS_LSB +: CTRL_BITS_W] < FRAME_BITS_MIN) ? FRAME_BITS_MIN :
                      (ctrl_q[CTRL_BITS_LSB +: CTRL_BITS_W] > FRAME_BITS_MAX) ? FRAME_BITS_MAX :
                      ctrl_q[CTRL_BITS_LSB +: CTRL_BITS_W];

  assign pin_takeover_o = rx_en;

  // input synchroniser: three stages, change taken when last two agree
  logic s1_q, s2_q, s3_q, line_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      line_q <= 1'b1;
    end else begin
      s1_q <= serial_input_pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        line_q <= s3_q;
      end
    end
  end

  // recovery state machine
  rx_state_t  state_q;
  logic [4:0] sample_q;
  logic [3:0] bit_idx_q;
  logic [1:0] votes_q;
  logic [9:0] shift_q;
  logic       prev_line_q;
  logic       frame_done;
  logic       frame_ferr;
  logic       noise_evt;

  logic [4:0] spb;
  logic [4:0] vote_first;
  logic [4:0] vote_last;
  logic       in_vote;
  logic       vote_one;
  assign spb        = dbl ? SPB_DOUBLE : SPB_NORMAL;
  assign vote_first = dbl ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
  assign vote_last  = vote_first + 5'h02;
  assign in_vote    = (sample_q >= vote_first) && (sample_q <= vote_last);
  // majority of three: earlier two high, or one high plus this high
  assign vote_one   = (votes_q == 2'h2) || ((votes_q == 2'h1) && line_q);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q     <= RX_IDLE;
      sample_q    <= 5'h00;
      bit_idx_q   <= 4'h0;
      votes_q     <= 2'h0;
      shift_q     <= 10'h000;
      prev_line_q <= 1'b1;
      frame_done  <= 1'b0;
      frame_ferr  <= 1'b0;
      noise_evt   <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      noise_evt  <= 1'b0;
      if (!rx_en) begin
        state_q     <= RX_IDLE;
        prev_line_q <= 1'b1;
      end else if (sample_tick_i) begin
        prev_line_q <= line_q;
        unique case (state_q)
          RX_IDLE: begin
            if (prev_line_q && !line_q) begin
              state_q  <= RX_START;
              sample_q <= 5'h02;
              votes_q  <= 2'h0;
            end
          end
          RX_START: begin
            sample_q <= sample_q + 5'h01;
            if (in_vote) begin
              votes_q <= votes_q + {1'b0, line_q};
              if (sample_q == vote_last) begin
                if (vote_one) begin
                  state_q   <= RX_IDLE;
                  noise_evt <= 1'b1;
                end else begin
                  // realign the bit counter to this start bit
                  state_q   <= RX_BITS;
                  bit_idx_q <= 4'h0;
                end
              end
            end
            if (sample_q == spb) begin
              sample_q  <= 5'h01;
              votes_q   <= 2'h0;
              bit_idx_q <= 4'h0;
            end
          end
          RX_BITS: begin
            sample_q <= (sample_q == spb) ? 5'h01 : sample_q + 5'h01;
            if (sample_q == spb) begin
              votes_q <= 2'h0;
            end else if (in_vote) begin
              votes_q <= votes_q + {1'b0, line_q};
            end
            if (in_vote && sample_q == vote_last) begin
              if (bit_idx_q == frame_bits) begin
                // first stop bit: leave now so the next edge is seen
                frame_ferr <= !vote_one;
                frame_done <= 1'b1;
                state_q    <= RX_IDLE;
              end else begin
                shift_q   <= {vote_one, shift_q[9:1]};
                bit_idx_q <= bit_idx_q + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  // align the lsb-first shift to bit zero for any frame length
  logic [9:0] char_data;
  assign char_data = shift_q >> (4'ha - frame_bits);

  // two-entry receive buffer holding data and framing error
  logic [9:0] fifo_data_q [FIFO_DEPTH];
  logic       fifo_ferr_q [FIFO_DEPTH];
  logic       rd_ptr_q, wr_ptr_q;
  logic [1:0] count_q;
  logic       overrun_q;
  logic       data_read;
  logic       push;
  logic       pop;
  assign data_read = read_i && (addr_i == ADDR_DATA);
  assign pop       = data_read && (count_q != 2'h0);
  assign push      = frame_done && ((count_q != 2'h2) || pop);

  always_ff @(posedge clk_i) begin
    if (reset_i || !rx_en) begin
      rd_ptr_q  <= 1'b0;
      wr_ptr_q  <= 1'b0;
      count_q   <= 2'h0;
      overrun_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
      // a full buffer loses the new frame; flagged until a frame gets in
      if (frame_done && !push) begin
        overrun_q <= 1'b1;
      end else if (push) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      fifo_data_q[wr_ptr_q] <= char_data;
      fifo_ferr_q[wr_ptr_q] <= frame_ferr;
    end
  end

  // control, interrupt and read data
  logic [IRQ_W-1:0] irq_evt;
  assign irq_evt = {noise_evt, frame_done && frame_ferr, push};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q   <= CTRL_RESET;
      irq_en_q <= '0;
    end else if (write_i) begin
      if (addr_i == ADDR_CTRL) begin
        ctrl_q <= wdata_i[7:0];
      end
      if (addr_i == ADDR_IRQ_EN) begin
        irq_en_q <= wdata_i[IRQ_W-1:0];
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~((write_i && addr_i == ADDR_IRQ_CLR) ? wdata_i[IRQ_W-1:0] : '0)) | irq_evt;
    end
  end

  assign irq_o = |(irq_st_q & irq_en_q);

  logic [15:0] status_word;
  logic        has_data;
  assign has_data = count_q != 2'h0;
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_DONE_BIT]  = has_data;
    status_word[ST_FERR_BIT]  = has_data && fifo_ferr_q[rd_ptr_q];
    status_word[ST_OVR_BIT]   = overrun_q;
    status_word[ST_DATA9_BIT] = has_data && fifo_data_q[rd_ptr_q][8];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 16'h0000;
    end else if (read_i) begin
      unique case (addr_i)
        ADDR_CTRL:   rdata_q <= {8'h00, ctrl_q};
        ADDR_STATUS: rdata_q <= status_word;
        ADDR_DATA:   rdata_q <= has_data ? {6'h00, fifo_data_q[rd_ptr_q]} : 16'h0000;
        ADDR_IRQ_ST: rdata_q <= {13'h0000, irq_st_q};
        ADDR_IRQ_EN: rdata_q <= {13'h0000, irq_en_q};
        default:     rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign rdata_o = rdata_q;

endmodule : rx_recovery
`default_nettype wire

// *** common/rx_recovery_pkg.sv ***
// constants for the asynchronous receiver recovery block
package rx_recovery_pkg;
  // register offsets (word index == byte address / 4 not used; plain port)
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_DATA    = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
  // control fields
  localparam int CTRL_RX_EN_BIT  = 0;
  localparam int CTRL_DBL_BIT    = 1;
  localparam int CTRL_BITS_LSB   = 4;
  localparam int CTRL_BITS_W     = 4;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  // status fields
  localparam int ST_DONE_BIT  = 0;
  localparam int ST_FERR_BIT  = 1;
  localparam int ST_OVR_BIT   = 2;
  localparam int ST_DATA9_BIT = 3;
  // interrupt events
  localparam int IRQ_W        = 3;
  localparam int IRQ_RX_BIT   = 0;
  localparam int IRQ_FERR_BIT = 1;
  localparam int IRQ_NOISE_BIT= 2;
  // sampling
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [3:0] FRAME_BITS_MIN = 4'h5;
  localparam logic [3:0] FRAME_BITS_MAX = 4'ha;
  localparam int FIFO_DEPTH = 2;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
endpackage : rx_recovery_pkg

// *** verification/rx_recovery_props.sv ***
// port checker for the receiver recovery block
`timescale 1ns/1ps
`default_nettype none
module rx_recovery_props
  import rx_recovery_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        sample_tick_i,
  input wire logic        serial_input_pin_i,
  input wire logic        pin_takeover_o,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [15:0] rdata_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic wc;
  logic off;
  assign wc  = write_i && addr_i == ADDR_CTRL;
  assign off = !pin_takeover_o;
  AST_TAKE_ON: assert property (wc && wdata_i[0] |=> pin_takeover_o)
    else $error("pin not taken");
  AST_TAKE_OFF: assert property (wc && !wdata_i[0] |=> off)
    else $error("pin not released");
  AST_FLUSH: assert property (off && !$past(pin_takeover_o) && read_i && addr_i == ADDR_STATUS |=> rdata_o[2:0] == 3'h0)
    else $error("status not flushed");
  AST_EMPTY: assert property (off && !$past(pin_takeover_o) && read_i && addr_i == ADDR_DATA |=> rdata_o == 16'h0)
    else $error("data after flush");
  AST_QUIET: assert property (off && !$past(pin_takeover_o) && !irq_o && !write_i && !$past(write_i) |=> !irq_o)
    else $error("event while off");
  AST_RD_IDLE: assert property (!read_i |=> rdata_o == 16'h0)
    else $error("stray read data");
  AST_MAP: assert property (read_i && addr_i > ADDR_IRQ_CLR |=> rdata_o == 16'h0)
    else $error("unmapped data");
  AST_DBL: assert property (wc ##1 read_i && addr_i == ADDR_CTRL |=> (rdata_o & 16'h3) == ($past(wdata_i, 2) & 16'h3))
    else $error("mode readback");
  AST_MASK: assert property (write_i && addr_i == ADDR_IRQ_EN && wdata_i[2:0] == 3'h0 ##1 !write_i |=> !irq_o)
    else $error("irq unmasked");
endmodule : rx_recovery_props
bind rx_recovery rx_recovery_props i_props (.clk_i(clk_i), .reset_i(reset_i), .sample_tick_i(sample_tick_i),
  .serial_input_pin_i(serial_input_pin_i), .pin_takeover_o(pin_takeover_o), .addr_i(addr_i), .wdata_i(wdata_i),
  .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// *** verification/rx_line_model.sv ***
// remote transmitter model on the serial line
`timescale 1ns/1ps
`default_nettype none
module rx_line_model (
  // clock and oversampling tick
  input  wire logic clk_i,
  input  wire logic tick_i,
  // serial line, idle high
  output logic      line_o
);
  initial line_o = 1'b1;
  // exact bit rate, no skew, well inside any error budget
  task automatic send(input logic [9:0] d, input int n, input int spb, input logic stop_v, input int stop_n);
    line_o <= 1'b0;
    repeat (spb) @(posedge clk_i iff tick_i);
    for (int i = 0; i < n; i++) begin
      line_o <= d[i];
      repeat (spb) @(posedge clk_i iff tick_i);
    end
    line_o <= stop_v;
    repeat (stop_n) @(posedge clk_i iff tick_i);
    if (!stop_v) line_o <= 1'b1;
  endtask : send
endmodule : rx_line_model
`default_nettype wire

// *** verification/rx_recovery_tb_top.sv ***
// self-checking bench for the receiver recovery block
`timescale 1ns/1ps
`default_nettype none
module rx_recovery_tb_top;
  import rx_recovery_pkg::*;
  logic        clk_i = 0, reset_i = 1, tick = 0, line, take, write_i = 0, read_i = 0, irq, rd_q = 0;
  logic [3:0]  addr_i = 0;
  logic [15:0] wdata_i = 0, rdata, d, e, m;
  logic [31:0] seed = 32'd60;
  logic [15:0] exp_q[$], msk_q[$], pd, pm;
  int          miscompares = 0, num_checks = 0, cyc = 0, nb[4] = '{8, 5, 10, 7};
  rx_line_model i_rx_line_model (.clk_i(clk_i), .tick_i(tick), .line_o(line));
  rx_recovery i_rx_recovery (.clk_i(clk_i), .reset_i(reset_i), .sample_tick_i(tick), .serial_input_pin_i(line),
    .pin_takeover_o(take), .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
    .rdata_o(rdata), .irq_o(irq));
  initial forever #25 clk_i = ~clk_i;
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  task automatic err(input logic [15:0] g, input logic [15:0] x);
    miscompares++;
    $display("[ERR] %0t got %h expected %h", $time, g, x);
  endtask : err
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // one tick every fourth clock; also the hang limit
  always @(posedge clk_i) begin
    cyc  <= cyc + 1;
    tick <= (cyc[1:0] == 2'd3);
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end
  always @(posedge clk_i) begin
    if (rd_q) begin
      pd = exp_q.pop_front();
      pm = msk_q.pop_front();
      num_checks++;
      if ((rdata & pm) !== (pd & pm)) err(rdata, pd);
    end
    rd_q <= read_i;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    addr_i  <= a;
    wdata_i <= v;
    write_i <= 1'b1;
    read_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] x, input logic [15:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    addr_i  <= a;
    read_i  <= 1'b1;
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  task automatic idle(input int n);
    write_i <= 1'b0;
    read_i  <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : idle
  task automatic frame(input logic dbl, input int n, input logic sv, input int sn, output logic [15:0] v);
    v = xs() & ((16'h1 << n) - 16'h1);
    i_rx_line_model.send(v[9:0], n, dbl ? 8 : 16, sv, sn);
    idle(20);
  endtask : frame
  task automatic chk(input logic x);
    num_checks++;
    if (irq !== x) err({15'h0, irq}, {15'h0, x});
  endtask : chk
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(ADDR_CTRL, {8'h00, CTRL_RESET}, 16'hffff);
    rd(4'hf, 16'h0, 16'hffff);
    wr(ADDR_IRQ_EN, 16'h7);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, {8'h0, nb[k][3:0], 2'h0, k[0], 1'b1});
      rd(ADDR_CTRL, {8'h0, nb[k][3:0], 2'h0, k[0], 1'b1}, 16'h00f3);
      frame(k[0], nb[k], 1'b1, k[0] ? 8 : 16, d);
      chk(1'b1);
      rd(ADDR_STATUS, 16'h1, 16'h3);
      rd(ADDR_DATA, d, 16'hffff);
      wr(ADDR_IRQ_CLR, 16'h7);
      rd(ADDR_STATUS, 16'h0, 16'h1);
      idle(2);
      chk(1'b0);
    end
    $display("modes done");
    wr(ADDR_CTRL, 16'h0081);
    idle(1);
    frame(1'b0, 8, 1'b1, 10, d);
    frame(1'b0, 8, 1'b0, 16, e);
    rd(ADDR_STATUS, 16'h1, 16'h3);
    rd(ADDR_DATA, d, 16'hffff);
    rd(ADDR_STATUS, 16'h3, 16'h3);
    rd(ADDR_DATA, e, 16'hffff);
    rd(ADDR_STATUS, 16'h0, 16'h1);
    wr(ADDR_IRQ_CLR, 16'h7);
    idle(1);
    i_rx_line_model.send(10'h0, 0, 3, 1'b1, 0);
    idle(80);
    rd(ADDR_IRQ_ST, 16'h4, 16'h7);
    rd(ADDR_STATUS, 16'h0, 16'h1);
    wr(ADDR_IRQ_EN, 16'h0);
    idle(3);
    chk(1'b0);
    $display("frames done");
    frame(1'b0, 8, 1'b1, 16, d);
    frame(1'b0, 8, 1'b1, 16, d);
    fork
      frame(1'b0, 8, 1'b1, 16, d);
      begin
        repeat (200) @(posedge clk_i);
        wr(ADDR_CTRL, 16'h0080);
        idle(1);
      end
    join
    wr(ADDR_IRQ_CLR, 16'h7);
    idle(1);
    rd(ADDR_STATUS, 16'h0, 16'h7);
    rd(ADDR_DATA, 16'h0, 16'hffff);
    wr(ADDR_CTRL, 16'h0081);
    rd(ADDR_STATUS, 16'h0, 16'h7);
    idle(4);
    $display("flush done");
    summarize();
  end
endmodule : rx_recovery_tb_top
`default_nettype wire
